/* File: inc/cmo_pkg.sv */
// Constants, field layouts and carrier types of the message object register set
package cmo_pkg;

  localparam int NUM_OBJ = 15;
  localparam logic [3:0] OBJ_MAX = 4'hE;

  // Avalon byte addresses, one word per register
  localparam logic [5:0] OFS_PAGE = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_CTRL = 6'h08;
  localparam logic [5:0] OFS_TAG4 = 6'h0C;
  localparam logic [5:0] OFS_TAG3 = 6'h10;
  localparam logic [5:0] OFS_TAG2 = 6'h14;
  localparam logic [5:0] OFS_TAG1 = 6'h18;
  localparam logic [5:0] OFS_DATA = 6'h1C;
  localparam logic [5:0] OFS_ENABLE = 6'h20;

  // Page select layout
  localparam int PAGE_OBJ_LSB = 4;
  localparam int PAGE_INDEX_AUTOINC_DISABLE_BIT = 3;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Status bit positions
  localparam int ST_LENWARN = 7;
  localparam int ST_TRANSMIT_COMPLETE_FLAG = 6;
  localparam int ST_RECEIVE_COMPLETE_FLAG = 5;
  localparam int ST_BITERR = 4;
  localparam int ST_STUFFERR = 3;
  localparam int ST_CRCERR = 2;
  localparam int ST_FORMERR = 1;
  localparam int ST_ACKERR = 0;

  // Control/length layout
  localparam int CTRL_CFG_LSB = 6;
  localparam int CTRL_REPLY_VALID_BIT = 5;
  localparam int CTRL_IDE_BIT = 4;
  localparam logic [3:0] DLC_MAX = 4'h8;

  // Identifier tag layout (32-bit tag, byte 1 at bits 31:24)
  localparam int TAG_STD_LSB = 21;
  localparam int TAG_EXT_LSB = 3;
  localparam int TAG_RTR = 2;
  localparam int TAG_RB1 = 1;
  localparam int TAG_RB0 = 0;

  // Bit-level checks
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [2:0] EOF_RX_DONE = 3'h6;
  localparam logic [2:0] EOF_TX_DONE = 3'h7;

  typedef enum logic [1:0] {
    CFG_OFF = 2'h0,
    CFG_TX = 2'h1,
    CFG_RX = 2'h2,
    CFG_FBUF = 2'h3
  } cmo_cfg_t;

  typedef enum logic [3:0] {
    FLD_IDLE = 4'h0,
    FLD_SOF = 4'h1,
    FLD_ARB = 4'h2,
    FLD_CTRL = 4'h3,
    FLD_DATA = 4'h4,
    FLD_CRC = 4'h5,
    FLD_CRCDEL = 4'h6,
    FLD_ACK = 4'h7,
    FLD_ACKDEL = 4'h8,
    FLD_EOF = 4'h9,
    FLD_INTER = 4'hA
  } cmo_field_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_RX = 3'b010,
    FR_TX = 3'b100
  } cmo_frame_t;

  typedef struct packed {
    logic valid;
    logic ide;
    logic [28:0] id;
    logic rtr;
    logic rb1;
    logic rb0;
    logic [3:0] dlc;
  } cmo_rxhdr_t;

  typedef struct packed {
    logic valid;
    logic rxBit;
    logic txBit;
    logic stuffBit;
    logic transmitting;
    logic arbitration;
    logic errFrame;
    cmo_field_t field;
  } cmo_bit_t;

  typedef struct packed {
    logic valid;
    logic [3:0] obj;
    logic ide;
    logic [28:0] id;
    logic rtr;
    logic rb1;
    logic rb0;
    logic [3:0] len;
  } cmo_txdesc_t;

  typedef struct packed {
    logic [7:0] page;
    logic [14:0][7:0] status;
    logic [14:0][7:0] ctrl;
    logic [14:0][31:0] tag;
    logic [14:0][7:0][7:0] data;
    logic [14:0] en;
    logic [14:0] done;
    logic [14:0] replyPend;
    logic ack;
    logic [31:0] rdata;
    cmo_frame_t frame;
    logic [3:0] act;
    logic actValid;
    logic [2:0] runLen;
    logic lastBit;
    logic [14:0] crc;
    logic [14:0] rxCrc;
    logic [2:0] eofCnt;
    logic frameErr;
    cmo_txdesc_t txd;
    logic [7:0] txByte;
  } cmo_state_t;

endpackage

/* File: hdl/cmo_msgobj_regs.sv */
// Message object register set with Avalon-MM slave and frame event checks
// Notes on behaviour
// - Page picks object; only 0..14 valid
// - Index auto-increment bit is active low
// - Three-bit index picks data buffer byte
// - Object registers need software initialisation
// - Length mismatch warns; received length always stored
// - Transmit complete at end of EOF; disable
// - Lowest numbered object sent or updated first
// - Receive complete after sixth EOF bit; disable
// - Bit error while sending, two exceptions
// - Flags cleared by status rewrite; errors keep enable
// - Six equal bits give stuff error
// - CRC over SOF..data checked on reception
// - Delimiters and EOF must be recessive
// - Recessive acknowledge slot gives ack error while sending
// - Config field: off, transmit, receive, buffer
// - Config rewrite re-enables and unlocks completion clear
// - Reply valid marks automatic reply ready
// - Extension bit selects 11/29 bits; received overwrites
// - Length above eight acts as eight
// - Identifier at 31:21 or 31:3, received overwrites
// - Unused standard tag bits loaded on reception
// - Remote tag cleared before automatic reply
// - Index wraps from seven to zero
`timescale 1ns/1ps

module cmo_msgobj_regs (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes, lane 0 used
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire cmo_pkg::cmo_rxhdr_t rxHdr, // Received header strobe
  input wire logic [14:0] hitMask, // Acceptance hits for rxHdr
  input wire logic rxByteValid, // Received data byte strobe
  input wire logic [2:0] rxByteIdx, // Received byte position
  input wire logic [7:0] rxByte, // Received byte
  input wire cmo_pkg::cmo_bit_t bitIn, // Per-bit frame information
  input wire logic [2:0] txByteIdx, // Byte wanted for transmission
  output cmo_pkg::cmo_txdesc_t txDesc, // Next object to send
  output logic [7:0] txByte, // Byte of the sending object
  output logic [14:0] objEnable // Per-object enable bits
);

  cmo_pkg::cmo_state_t st_q;
  cmo_pkg::cmo_state_t st_d;

  logic [14:0] txCand;
  logic [14:0] rxCand;
  logic [4:0] txSel;
  logic [4:0] rxSel;
  logic [3:0] pageObj;
  logic pageOk;
  logic busReq;
  logic [7:0] regRd;
  logic [7:0] stNew;
  logic [7:0] errSet;
  logic [2:0] runNext;
  logic [2:0] eofNext;
  logic crcFb;
  logic [2:0] idx;
  logic [31:0] tagRx;
  logic [3:0] txo;

  // Lowest set bit wins: {found, index}
  function automatic logic [4:0] lowest(input logic [14:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = cmo_pkg::NUM_OBJ - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Candidates for transmission and reception
  always_comb begin
    for (int i = 0; i < cmo_pkg::NUM_OBJ; i++) begin
      txCand[i] = (st_q.en[i] && st_q.ctrl[i][7:6] == cmo_pkg::CFG_TX) || st_q.replyPend[i];
      rxCand[i] = st_q.en[i] && st_q.ctrl[i][7] && hitMask[i];
    end
  end

  assign txSel = lowest(txCand);
  assign rxSel = lowest(rxCand);

  assign pageObj = st_q.page[7:cmo_pkg::PAGE_OBJ_LSB];
  assign pageOk = pageObj <= cmo_pkg::OBJ_MAX;
  assign busReq = (avs_read || avs_write) && !st_q.ack;
  assign idx = st_q.page[2:0];

  // Register read mux for the selected page
  always_comb begin
    regRd = 8'h00;
    case (avs_address)
      cmo_pkg::OFS_PAGE: regRd = st_q.page;
      cmo_pkg::OFS_ENABLE: regRd = 8'h00;
      default: regRd = 8'h00;
    endcase
    if (pageOk) begin
      case (avs_address)
        cmo_pkg::OFS_STATUS: regRd = st_q.status[pageObj];
        cmo_pkg::OFS_CTRL: regRd = st_q.ctrl[pageObj];
        cmo_pkg::OFS_TAG4: regRd = st_q.tag[pageObj][7:0];
        cmo_pkg::OFS_TAG3: regRd = st_q.tag[pageObj][15:8];
        cmo_pkg::OFS_TAG2: regRd = st_q.tag[pageObj][23:16];
        cmo_pkg::OFS_TAG1: regRd = st_q.tag[pageObj][31:24];
        cmo_pkg::OFS_DATA: regRd = st_q.data[pageObj][idx];
        default: regRd = regRd;
      endcase
    end
  end

  // Received tag; standard frames fill bits 20:3 and 1 with zero
  always_comb begin
    if (rxHdr.ide) begin
      tagRx = {rxHdr.id, rxHdr.rtr, rxHdr.rb1, rxHdr.rb0};
    end else begin
      tagRx = {rxHdr.id[10:0], 18'h00000, rxHdr.rtr, 1'b0, rxHdr.rb0};
    end
  end

  always_comb begin
    st_d = st_q;
    stNew = 8'h00;
    errSet = 8'h00;
    runNext = 3'h0;
    eofNext = 3'h0;
    crcFb = 1'b0;
    txo = txSel[3:0];
    if (ce) begin
      st_d.ack = 1'b0;
      // Bus side first, so hardware sets below win over a clear
      if (busReq) begin
        st_d.ack = 1'b1;
        if (avs_read) begin
          st_d.rdata = {24'h000000, regRd};
          if (avs_address == cmo_pkg::OFS_ENABLE) begin
            st_d.rdata = {17'h00000, st_q.en};
          end
        end
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == cmo_pkg::OFS_PAGE) begin
            st_d.page = avs_writedata[7:0];
          end else if (pageOk) begin
            case (avs_address)
              cmo_pkg::OFS_STATUS: begin
                stNew = avs_writedata[7:0];
                if (st_q.done[pageObj]) begin
                  // Completion flags stay until the config is rewritten
                  stNew[cmo_pkg::ST_TRANSMIT_COMPLETE_FLAG] = stNew[cmo_pkg::ST_TRANSMIT_COMPLETE_FLAG] | st_q.status[pageObj][cmo_pkg::ST_TRANSMIT_COMPLETE_FLAG];
                  stNew[cmo_pkg::ST_RECEIVE_COMPLETE_FLAG] = stNew[cmo_pkg::ST_RECEIVE_COMPLETE_FLAG] | st_q.status[pageObj][cmo_pkg::ST_RECEIVE_COMPLETE_FLAG];
                end
                st_d.status[pageObj] = stNew;
              end
              cmo_pkg::OFS_CTRL: begin
                st_d.ctrl[pageObj] = avs_writedata[7:0];
                st_d.en[pageObj] = avs_writedata[7:6] != cmo_pkg::CFG_OFF;
                st_d.done[pageObj] = 1'b0;
                st_d.replyPend[pageObj] = 1'b0;
              end
              cmo_pkg::OFS_TAG4: st_d.tag[pageObj][7:0] = avs_writedata[7:0];
              cmo_pkg::OFS_TAG3: st_d.tag[pageObj][15:8] = avs_writedata[7:0];
              cmo_pkg::OFS_TAG2: st_d.tag[pageObj][23:16] = avs_writedata[7:0];
              cmo_pkg::OFS_TAG1: st_d.tag[pageObj][31:24] = avs_writedata[7:0];
              cmo_pkg::OFS_DATA: st_d.data[pageObj][idx] = avs_writedata[7:0];
              default: st_d.page = st_d.page;
            endcase
          end
        end
        // Any data access moves the index on unless frozen; 3 bits wrap 7 to 0
        if (avs_address == cmo_pkg::OFS_DATA && !st_q.page[cmo_pkg::PAGE_INDEX_AUTOINC_DISABLE_BIT]) begin
          st_d.page[2:0] = idx + 3'h1;
        end
      end

      // Received header goes to the lowest enabled receive object with its hitMask bit set only
      if (rxHdr.valid && st_q.frame == cmo_pkg::FR_RX) begin
        st_d.actValid = rxSel[4];
        st_d.act = rxSel[3:0];
        if (rxSel[4]) begin
          if (rxHdr.dlc != st_q.ctrl[rxSel[3:0]][3:0]) begin
            st_d.status[rxSel[3:0]][cmo_pkg::ST_LENWARN] = 1'b1;
          end
          st_d.ctrl[rxSel[3:0]][3:0] = rxHdr.dlc;
          st_d.ctrl[rxSel[3:0]][cmo_pkg::CTRL_IDE_BIT] = rxHdr.ide;
          st_d.tag[rxSel[3:0]] = tagRx;
        end
      end

      if (rxByteValid && st_q.actValid && st_q.frame == cmo_pkg::FR_RX) begin
        st_d.data[st_q.act][rxByteIdx] = rxByte;
      end

      // Bit-level checks
      if (bitIn.valid) begin
        runNext = (bitIn.rxBit == st_q.lastBit && st_q.runLen != 3'h7) ? st_q.runLen + 3'h1 : 3'h1;
        if (bitIn.field == cmo_pkg::FLD_SOF) begin
          st_d.runLen = 3'h1;
          st_d.crc = 15'h0000;
          st_d.eofCnt = 3'h0;
          st_d.frameErr = 1'b0;
          runNext = 3'h1;
          if (bitIn.transmitting && txSel[4]) begin
            st_d.frame = cmo_pkg::FR_TX;
            st_d.act = txSel[3:0];
            st_d.actValid = 1'b1;
          end else begin
            st_d.frame = cmo_pkg::FR_RX;
            st_d.actValid = 1'b0;
          end
        end else if (st_q.frame == cmo_pkg::FR_TX && !bitIn.transmitting) begin
          // Lost arbitration: carry on as a receiver
          st_d.frame = cmo_pkg::FR_RX;
          st_d.actValid = 1'b0;
        end
        if (bitIn.field inside {cmo_pkg::FLD_SOF, cmo_pkg::FLD_ARB, cmo_pkg::FLD_CTRL,
                                cmo_pkg::FLD_DATA, cmo_pkg::FLD_CRC}) begin
          st_d.runLen = runNext;
          st_d.lastBit = bitIn.rxBit;
          if (st_q.runLen >= cmo_pkg::STUFF_LIMIT && bitIn.rxBit == st_q.lastBit &&
              bitIn.field != cmo_pkg::FLD_SOF) begin
            errSet[cmo_pkg::ST_STUFFERR] = 1'b1;
          end
        end
        if (!bitIn.stuffBit) begin
          if (bitIn.field inside {cmo_pkg::FLD_SOF, cmo_pkg::FLD_ARB, cmo_pkg::FLD_CTRL, cmo_pkg::FLD_DATA}) begin
            crcFb = bitIn.rxBit ^ st_d.crc[14];
            st_d.crc = {st_d.crc[13:0], 1'b0} ^ (crcFb ? cmo_pkg::CRC_POLY : 15'h0000);
          end
          if (bitIn.field == cmo_pkg::FLD_CRC) begin
            st_d.rxCrc = {st_q.rxCrc[13:0], bitIn.rxBit};
          end
        end
        if (bitIn.field inside {cmo_pkg::FLD_CRCDEL, cmo_pkg::FLD_ACKDEL, cmo_pkg::FLD_EOF} && !bitIn.rxBit) begin
          errSet[cmo_pkg::ST_FORMERR] = 1'b1;
        end
        if (bitIn.field == cmo_pkg::FLD_CRCDEL && st_q.frame == cmo_pkg::FR_RX && st_q.rxCrc != st_q.crc) begin
          errSet[cmo_pkg::ST_CRCERR] = 1'b1;
        end
        if (bitIn.field == cmo_pkg::FLD_ACK && st_q.frame == cmo_pkg::FR_TX && bitIn.rxBit) begin
          errSet[cmo_pkg::ST_ACKERR] = 1'b1;
        end
        // Arbitration loss and a dominant ack during an error frame are not bit errors
        if (bitIn.transmitting && bitIn.rxBit != bitIn.txBit &&
            !(bitIn.arbitration && bitIn.txBit && !bitIn.rxBit) &&
            !(bitIn.errFrame && bitIn.field == cmo_pkg::FLD_ACK && !bitIn.rxBit)) begin
          errSet[cmo_pkg::ST_BITERR] = 1'b1;
        end
        if (errSet != 8'h00) begin
          st_d.frameErr = 1'b1;
          if (st_q.actValid) begin
            // Errors leave the enable bit alone
            st_d.status[st_q.act] = st_d.status[st_q.act] | errSet;
          end
        end
        if (bitIn.field == cmo_pkg::FLD_EOF) begin
          eofNext = st_q.eofCnt + 3'h1;
          st_d.eofCnt = eofNext;
          if (st_q.actValid && !st_q.frameErr && errSet == 8'h00) begin
            if (st_q.frame == cmo_pkg::FR_RX && eofNext == cmo_pkg::EOF_RX_DONE) begin
              st_d.status[st_q.act][cmo_pkg::ST_RECEIVE_COMPLETE_FLAG] = 1'b1;
              if (st_q.tag[st_q.act][cmo_pkg::TAG_RTR] && st_q.ctrl[st_q.act][cmo_pkg::CTRL_REPLY_VALID_BIT]) begin
                st_d.tag[st_q.act][cmo_pkg::TAG_RTR] = 1'b0;
                st_d.replyPend[st_q.act] = 1'b1;
              end else begin
                st_d.en[st_q.act] = 1'b0;
                st_d.done[st_q.act] = 1'b1;
              end
            end
            if (st_q.frame == cmo_pkg::FR_TX && eofNext == cmo_pkg::EOF_TX_DONE) begin
              st_d.status[st_q.act][cmo_pkg::ST_TRANSMIT_COMPLETE_FLAG] = 1'b1;
              st_d.en[st_q.act] = 1'b0;
              st_d.done[st_q.act] = 1'b1;
              st_d.replyPend[st_q.act] = 1'b0;
            end
          end
          if (eofNext == cmo_pkg::EOF_TX_DONE) begin
            st_d.frame = cmo_pkg::FR_IDLE;
          end
        end
        if (bitIn.errFrame || bitIn.field == cmo_pkg::FLD_IDLE) begin
          st_d.frame = cmo_pkg::FR_IDLE;
          st_d.actValid = 1'b0;
        end
      end

      // Transmit descriptor of the lowest candidate, length capped at eight
      st_d.txd.valid = txSel[4];
      st_d.txd.obj = txo;
      st_d.txd.ide = st_q.ctrl[txo][cmo_pkg::CTRL_IDE_BIT];
      st_d.txd.id = st_q.ctrl[txo][cmo_pkg::CTRL_IDE_BIT] ? st_q.tag[txo][31:cmo_pkg::TAG_EXT_LSB]
                                                          : {18'h00000, st_q.tag[txo][31:cmo_pkg::TAG_STD_LSB]};
      st_d.txd.rtr = st_q.tag[txo][cmo_pkg::TAG_RTR];
      st_d.txd.rb1 = st_q.tag[txo][cmo_pkg::TAG_RB1];
      st_d.txd.rb0 = st_q.tag[txo][cmo_pkg::TAG_RB0];
      st_d.txd.len = (st_q.ctrl[txo][3:0] > cmo_pkg::DLC_MAX) ? cmo_pkg::DLC_MAX : st_q.ctrl[txo][3:0];
      st_d.txByte = st_q.data[(st_q.frame == cmo_pkg::FR_TX) ? st_q.act : txo][txByteIdx];
    end
  end

  // Object contents are cleared for determinism only; software must still set them up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.page <= cmo_pkg::PAGE_RESET;
      st_q.frame <= cmo_pkg::FR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign txDesc = st_q.txd;
  assign txByte = st_q.txByte;
  assign objEnable = st_q.en;

endmodule

/* File: bench/cmo_bus_partner.sv */
// Model of the other bus nodes: frame bits, header and data strobes
`timescale 1ns/1ps
module cmo_bus_partner (
  input wire logic clk, // Clock
  output cmo_pkg::cmo_rxhdr_t rxHdr, // Header strobe
  output logic [14:0] hitMask, // Hits
  output logic rxByteValid, // Byte strobe
  output logic [2:0] rxByteIdx, // Byte index
  output logic [7:0] rxByte, // Byte
  output cmo_pkg::cmo_bit_t bitIn // Bit info
);
  initial begin
    rxHdr = '0;
    hitMask = '0;
    rxByteValid = 1'b0;
    rxByteIdx = 3'h0;
    rxByte = 8'h00;
    bitIn = '0;
  end
  // Sent level always equals bus level, so no bit error is provoked
  task automatic bt(input logic r, input cmo_pkg::cmo_field_t f, input logic t);
    @(posedge clk);
    rxHdr.valid <= 1'b0;
    rxByteValid <= 1'b0;
    bitIn <= '{1'b1, r, r, 1'b0, t, 1'b0, 1'b0, f};
  endtask
  // Only the start bit feeds the CRC, so an empty CRC field matches
  task automatic frame(input cmo_pkg::cmo_rxhdr_t h, input logic [14:0] m, input logic t,
    input logic ack, input logic eof);
    int i;
    bt(1'b0, cmo_pkg::FLD_SOF, t);
    @(posedge clk);
    bitIn.valid <= 1'b0;
    rxHdr <= h;
    hitMask <= m;
    for (i = 0; i < h.dlc; i++) begin
      @(posedge clk);
      rxHdr.valid <= 1'b0;
      rxByteValid <= 1'b1;
      rxByteIdx <= i[2:0];
      rxByte <= 8'hA0 + i[7:0];
    end
    bt(1'b1, cmo_pkg::FLD_CRCDEL, t);
    bt(ack, cmo_pkg::FLD_ACK, t);
    bt(1'b1, cmo_pkg::FLD_ACKDEL, t);
    for (i = 0; i < 7; i++) begin
      bt(eof, cmo_pkg::FLD_EOF, t);
    end
    bt(1'b1, cmo_pkg::FLD_IDLE, 1'b0);
    @(posedge clk);
    bitIn.valid <= 1'b0;
  endtask
endmodule

/* File: bench/cmo_msgobj_regs_monitor.sv */
// Checker of bus answer, enable bits and transmit descriptor
`timescale 1ns/1ps
module cmo_msgobj_regs_monitor (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic ce, // Enable
  input wire logic [5:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic avs_waitrequest, // Stall
  input wire cmo_pkg::cmo_bit_t bitIn, // Bit info
  input wire cmo_pkg::cmo_txdesc_t txDesc, // Candidate
  input wire logic [14:0] objEnable // Enables
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] pgObj_q;
  logic take;
  logic ctlWr;
  assign take = (avs_read | avs_write) & avs_waitrequest & ce;
  assign ctlWr = take & avs_write & avs_byteenable[0] & (avs_address == cmo_pkg::OFS_CTRL);
  // Shadow of the selected object, needed to know which enable a write hits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pgObj_q <= 4'h0;
    end else if (take & avs_write & avs_byteenable[0] & (avs_address == cmo_pkg::OFS_PAGE)) begin
      pgObj_q <= avs_writedata[7:4];
    end
  end
  sequence s_take;
    take ##1 ce;
  endsequence
  property p_ans;
    s_take |-> !avs_waitrequest;
  endproperty
  property p_cfgOn;
    ctlWr && avs_writedata[7:6] != 2'h0 && pgObj_q <= cmo_pkg::OBJ_MAX |=> objEnable[pgObj_q];
  endproperty
  property p_cfgOff;
    ctlWr && avs_writedata[7:6] == 2'h0 && pgObj_q <= cmo_pkg::OBJ_MAX |=> !objEnable[pgObj_q];
  endproperty
  property p_inval;
    ctlWr && pgObj_q > cmo_pkg::OBJ_MAX && !bitIn.valid |=> objEnable == $past(objEnable);
  endproperty
  property p_up;
    |(objEnable & ~$past(objEnable)) |-> $past(ctlWr);
  endproperty
  property p_down;
    |($past(objEnable) & ~objEnable) |-> $past(ctlWr) || $past(bitIn.valid && bitIn.field == cmo_pkg::FLD_EOF);
  endproperty
  property p_len;
    txDesc.valid |-> txDesc.len <= cmo_pkg::DLC_MAX;
  endproperty
  property p_txEn;
    txDesc.valid && $stable(objEnable) |-> txDesc.obj <= cmo_pkg::OBJ_MAX && objEnable[txDesc.obj];
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  a_cfgOn: assert property (p_cfgOn) else $error("config write did not enable");
  a_cfgOff: assert property (p_cfgOff) else $error("config off did not disable");
  a_inval: assert property (p_inval) else $error("invalid page changed enables");
  a_up: assert property (p_up) else $error("enable rose without config write");
  a_down: assert property (p_down) else $error("enable fell outside end of frame");
  a_len: assert property (p_len) else $error("length above eight");
  a_txEn: assert property (p_txEn) else $error("candidate not enabled");
endmodule

bind cmo_msgobj_regs cmo_msgobj_regs_monitor mon_u (.clk, .rst_n, .ce, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .bitIn, .txDesc, .objEnable);

/* File: bench/cmo_msgobj_regs_test.sv */
// Self-checking bench of the message object register set
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module cmo_msgobj_regs_test;
  localparam logic [5:0] PG = 6'h00, ST = 6'h04, CT = 6'h08, T4 = 6'h0C, T2 = 6'h14, T1 = 6'h18;
  localparam logic [5:0] DT = 6'h1C, EN = 6'h20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  cmo_pkg::cmo_rxhdr_t rxHdr;
  cmo_pkg::cmo_rxhdr_t h0 = '0;
  cmo_pkg::cmo_bit_t bitIn;
  cmo_pkg::cmo_txdesc_t txDesc;
  logic [14:0] hitMask;
  logic [14:0] objEnable;
  logic rxByteValid;
  logic [2:0] rxByteIdx;
  logic [7:0] rxByte;
  logic [7:0] txByte;
  int errors = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  cmo_msgobj_regs dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .rxHdr(rxHdr), .hitMask(hitMask), .rxByteValid(rxByteValid),
    .rxByteIdx(rxByteIdx), .rxByte(rxByte), .bitIn(bitIn), .txByteIdx(3'h0), .txDesc(txDesc),
    .txByte(txByte), .objEnable(objEnable));
  cmo_bus_partner pu (.clk(clk), .rxHdr(rxHdr), .hitMask(hitMask), .rxByteValid(rxByteValid),
    .rxByteIdx(rxByteIdx), .rxByte(rxByte), .bitIn(bitIn));
  task automatic end_sim();
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Waitrequest and read data are sampled at the rising edge that completes the request
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      errors++;
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic get(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  task automatic t_reset();
    get("page", PG, 32'h00);
    get("status", ST, 32'h00);
    put(6'h24, 8'hFF);
    get("unmapped", 6'h24, 32'h0);
    put(PG, 8'hF0);
    put(CT, 8'h40);
    get("badCtl", CT, 32'h0);
    get("badEn", EN, 32'h0);
  endtask
  task automatic t_index();
    put(PG, 8'h36);
    put(DT, 8'hA6);
    put(DT, 8'hA7);
    put(DT, 8'hB0);
    put(CT, 8'h00);
    put(PG, 8'h36);
    get("idx", PG, 32'h36);
    get("d6", DT, 32'hA6);
    get("d7", DT, 32'hA7);
    get("wrap", DT, 32'hB0);
    put(PG, 8'h39);
    put(DT, 8'h55);
    get("fixed", DT, 32'h55);
    get("fixIdx", PG, 32'h39);
  endtask
  task automatic t_rx();
    cmo_pkg::cmo_rxhdr_t h;
    h = '{1'b1, 1'b1, 29'h1ABCDE12, 1'b0, 1'b0, 1'b0, 4'h2};
    put(PG, 8'h50);
    put(CT, 8'h84);
    put(PG, 8'h20);
    put(CT, 8'h84);
    get("rxEn", EN, 32'h24);
    pu.frame(h, 15'h0024, 1'b0, 1'b0, 1'b1);
    get("rxEn2", EN, 32'h20);
    get("rxSt", ST, 32'hA0);
    get("rxCtl", CT, 32'h92);
    get("rxT1", T1, 32'hD5);
    get("rxT4", T4, 32'h90);
    get("rxD0", DT, 32'hA0);
    put(ST, 8'h00);
    get("keep", ST, 32'h20);
    put(CT, 8'h82);
    put(ST, 8'h00);
    get("clr", ST, 32'h0);
    // Header must arrive so the error has an object to land on
    pu.frame(h, 15'h0004, 1'b0, 1'b0, 1'b0);
    get("form", ST, 32'h02);
    get("formEn", EN, 32'h24);
  endtask
  task automatic t_tx();
    put(PG, 8'h10);
    put(T1, 8'hAB);
    put(T2, 8'hE0);
    put(DT, 8'h3C);
    put(CT, 8'h49);
    put(PG, 8'h40);
    put(CT, 8'h41);
    repeat (3) @(negedge clk);
    `CHK("txObj", 4'h1, txDesc.obj)
    `CHK("txLen", 4'h8, txDesc.len)
    `CHK("txId", 11'h55F, txDesc.id[10:0])
    `CHK("txB0", 8'h3C, txByte)
    pu.frame(h0, 15'h0, 1'b1, 1'b0, 1'b1);
    put(PG, 8'h10);
    get("txSt", ST, 32'h40);
    get("txEn", EN, 32'h34);
    repeat (3) @(negedge clk);
    `CHK("txNext", 4'h4, txDesc.obj)
    pu.frame(h0, 15'h0, 1'b1, 1'b1, 1'b1);
    put(PG, 8'h40);
    get("ackSt", ST, 32'h01);
    get("ackEn", EN, 32'h34);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_index();
    t_rx();
    t_tx();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
